// ==== design/int_multiply_divide_unit.sv ====
// integer multiply/divide unit with private upper/bottom result registers
// Function
// - a 32-bit by 32-bit multiply gives 64 bits, upper half to the upper result register, lower half to the bottom.
// - in the wide variant a 64-bit by 64-bit multiply gives 128 bits spread over the two result registers.
// - reading a result register while an operation runs stalls the pipeline until the unit is done.
// - a divide leaves the quotient in the bottom and the remainder in the upper result register.
// - in the baseline a multiply takes 12 clocks and a divide 35 clocks.
// - latencies are parameters per variant, such as 10, 42, 12 and 74 clocks for the wide variant.
// - result registers update the moment the result is ready, not at pipeline writeback.
// - an operation under way keeps running and overwrites the result registers while an exception is handled.
// - a move-from copies the upper or bottom result register out to a general register.
// - a move-to loads the upper or bottom result register from a general register.
// - with accumulate enabled, signed and unsigned multiply-accumulate add the product into the register pair.
// - with accumulate enabled, a three-operand multiply writes its product to a general register after 4 clocks.
// - the three-operand multiply leaves both result registers untouched.
// - the stall output stands through every long operation, divide or multiply, not only while a result register read waits.
`timescale 1ns/1ps
module int_multiply_divide_unit import imdu_pkg::*; #(
  parameter bit         WIDE_EN    = 1'b0,
  parameter bit         ACC_EN     = 1'b0,
  parameter logic [6:0] MUL_W_LAT  = LAT_MUL_W_BASE,
  parameter logic [6:0] DIV_W_LAT  = LAT_DIV_W_BASE,
  parameter logic [6:0] MUL_D_LAT  = LAT_MUL_D,
  parameter logic [6:0] DIV_D_LAT  = LAT_DIV_D,
  parameter logic [6:0] ACCUM_LAT  = LAT_ACCUM,
  parameter logic [6:0] MUL3_LAT   = LAT_MUL3
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // issue from the integer pipeline
  input  wire logic        cmdValid,
  input  wire cmd_t        cmd,
  // result register read
  input  wire logic        rdReq,
  input  wire logic        rdUpper,
  output logic             stall,
  output logic             rdValid,
  output logic [63:0]      rdData,
  // three-operand product write back
  output logic             gprWrValid,
  output logic [4:0]       gprWrDest,
  output logic [63:0]      gprWrData
);

  state_t      state_ff;
  logic [6:0]  cnt_ff;
  op_t         op_ff;
  logic        sgn_ff;
  logic [63:0] a_ff;
  logic [63:0] b_ff;
  logic [63:0] resultUpperReg_ff;
  logic [63:0] resultBottomReg_ff;
  logic        rdValid_ff;
  logic [63:0] rdData_ff;
  logic [6:0]  m3Cnt_ff;
  logic [63:0] m3Res_ff;
  logic [4:0]  m3Dest_ff;
  logic        gprWrValid_ff;
  logic [63:0] gprWrData_ff;
  logic [4:0]  gprWrDest_ff;

  logic        longStart;
  logic        mul3Start;
  logic        busy;
  logic        done;
  logic [6:0]  startLat;
  logic [32:0] ea33;
  logic [32:0] eb33;
  logic [64:0] ea65;
  logic [64:0] eb65;
  logic signed [65:0]  prodW;
  logic signed [129:0] prodD;
  logic [32:0] qW;
  logic [32:0] rW;
  logic [64:0] qD;
  logic [64:0] rD;
  logic [63:0] acc;
  logic [63:0] resHi;
  logic [63:0] resLo;
  logic [63:0] m3Prod;

  function automatic logic [63:0] sext32(input logic [31:0] x);
    sext32 = {{32{x[31]}}, x};
  endfunction

  function automatic logic isLong(input op_t o);
    case (o)
      OP_WORD_PRODUCT, OP_WORD_QUOTIENT: isLong = 1'b1;
      OP_WIDE_PRODUCT, OP_WIDE_QUOTIENT: isLong = WIDE_EN;
      OP_ACCUM:                          isLong = ACC_EN;
      default:                           isLong = 1'b0;
    endcase
  endfunction

  assign busy      = (state_ff == ST_RUN);
  assign done      = busy && (cnt_ff == 7'h01);
  assign longStart = cmdValid && isLong(cmd.op);
  assign mul3Start = cmdValid && ACC_EN && (cmd.op == OP_MUL3);

  always_comb begin
    case (cmd.op)
      OP_WORD_PRODUCT:  startLat = MUL_W_LAT;
      OP_WORD_QUOTIENT: startLat = DIV_W_LAT;
      OP_WIDE_PRODUCT:  startLat = MUL_D_LAT;
      OP_WIDE_QUOTIENT: startLat = DIV_D_LAT;
      OP_ACCUM:         startLat = ACCUM_LAT;
      default:          startLat = MUL_W_LAT;
    endcase
  end

  // sequencer; a new start while running restarts, the issuer keeps going meanwhile
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= CNT_RST;
    end else if (longStart) begin
      state_ff <= ST_RUN;
      cnt_ff   <= startLat;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          cnt_ff <= CNT_RST;
        end
        ST_RUN: begin
          // no abort input: an exception elsewhere never stops a running operation
          cnt_ff <= cnt_ff - 7'h01;
          if (done) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          cnt_ff   <= CNT_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      op_ff  <= OP_NONE;
      sgn_ff <= 1'b0;
      a_ff   <= RESULT_RST;
      b_ff   <= RESULT_RST;
    end else if (longStart) begin
      op_ff  <= cmd.op;
      sgn_ff <= cmd.isSigned;
      a_ff   <= cmd.a;
      b_ff   <= cmd.b;
    end
  end

  // operands are widened by one bit so signed and unsigned share one datapath
  always_comb begin
    ea33  = {sgn_ff & a_ff[31], a_ff[31:0]};
    eb33  = {sgn_ff & b_ff[31], b_ff[31:0]};
    ea65  = {sgn_ff & a_ff[63], a_ff};
    eb65  = {sgn_ff & b_ff[63], b_ff};
    prodW = $signed(ea33) * $signed(eb33);
    prodD = $signed(ea65) * $signed(eb65);
    // divide by zero: quotient all ones, remainder the dividend
    if (eb33 == 33'h0) begin
      qW = '1;
      rW = ea33;
    end else begin
      qW = 33'($signed(ea33) / $signed(eb33));
      rW = 33'($signed(ea33) % $signed(eb33));
    end
    if (eb65 == 65'h0) begin
      qD = '1;
      rD = ea65;
    end else begin
      qD = 65'($signed(ea65) / $signed(eb65));
      rD = 65'($signed(ea65) % $signed(eb65));
    end
    acc = {resultUpperReg_ff[31:0], resultBottomReg_ff[31:0]} + prodW[63:0];
    case (op_ff)
      OP_WORD_PRODUCT: begin
        resHi = sext32(prodW[63:32]);
        resLo = sext32(prodW[31:0]);
      end
      OP_WORD_QUOTIENT: begin
        resHi = sext32(rW[31:0]);
        resLo = sext32(qW[31:0]);
      end
      OP_WIDE_PRODUCT: begin
        resHi = prodD[127:64];
        resLo = prodD[63:0];
      end
      OP_WIDE_QUOTIENT: begin
        resHi = rD[63:0];
        resLo = qD[63:0];
      end
      OP_ACCUM: begin
        resHi = sext32(acc[63:32]);
        resLo = sext32(acc[31:0]);
      end
      default: begin
        resHi = resultUpperReg_ff;
        resLo = resultBottomReg_ff;
      end
    endcase
  end

  // written at the completion edge itself; a move-to in the same cycle wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resultUpperReg_ff  <= RESULT_RST;
      resultBottomReg_ff <= RESULT_RST;
    end else begin
      if (cmdValid && cmd.op == OP_LOAD_UPPER) begin
        resultUpperReg_ff <= cmd.a;
      end else if (done) begin
        resultUpperReg_ff <= resHi;
      end
      if (cmdValid && cmd.op == OP_LOAD_BOTTOM) begin
        resultBottomReg_ff <= cmd.a;
      end else if (done) begin
        resultBottomReg_ff <= resLo;
      end
    end
  end

  // reads are only served once idle; the stall flag holds the pipeline off
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdValid_ff <= 1'b0;
      rdData_ff  <= RESULT_RST;
    end else begin
      rdValid_ff <= rdReq && !busy;
      if (rdReq && !busy) begin
        rdData_ff <= rdUpper ? resultUpperReg_ff : resultBottomReg_ff;
      end
    end
  end

  // three-operand multiply runs on its own counter, away from the result pair
  assign m3Prod = 64'($signed({cmd.isSigned & cmd.a[31], cmd.a[31:0]}) *
                      $signed({cmd.isSigned & cmd.b[31], cmd.b[31:0]}));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      m3Cnt_ff  <= CNT_RST;
      m3Res_ff  <= RESULT_RST;
      m3Dest_ff <= 5'h00;
    end else if (mul3Start) begin
      m3Cnt_ff  <= MUL3_LAT;
      m3Res_ff  <= sext32(m3Prod[31:0]);
      m3Dest_ff <= cmd.dest;
    end else if (m3Cnt_ff != CNT_RST) begin
      m3Cnt_ff <= m3Cnt_ff - 7'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gprWrValid_ff <= 1'b0;
      gprWrData_ff  <= RESULT_RST;
      gprWrDest_ff  <= 5'h00;
    end else begin
      gprWrValid_ff <= (m3Cnt_ff == 7'h01) && !mul3Start;
      if (m3Cnt_ff == 7'h01) begin
        gprWrData_ff <= m3Res_ff;
        gprWrDest_ff <= m3Dest_ff;
      end
    end
  end

  logic stall_ff;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stall_ff <= 1'b0;
    end else begin
      stall_ff <= longStart || (busy && !done);
    end
  end

  assign stall      = stall_ff;
  assign rdValid    = rdValid_ff;
  assign rdData     = rdData_ff;
  assign gprWrValid = gprWrValid_ff;
  assign gprWrData  = gprWrData_ff;
  assign gprWrDest  = gprWrDest_ff;

  // helper counters watched by the checks below
  logic [6:0] elapsed_ff;
  logic [6:0] latSel_ff;
  logic [6:0] m3Elapsed_ff;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      elapsed_ff   <= CNT_RST;
      latSel_ff    <= CNT_RST;
      m3Elapsed_ff <= CNT_RST;
    end else begin
      if (longStart) begin
        elapsed_ff <= 7'h01;
        latSel_ff  <= startLat;
      end else if (busy) begin
        elapsed_ff <= elapsed_ff + 7'h01;
      end
      m3Elapsed_ff <= mul3Start ? 7'h01 : m3Elapsed_ff + 7'h01;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_WORD_PRODUCT: assert property (
    done && !longStart && op_ff == OP_WORD_PRODUCT && !sgn_ff && !(cmdValid && cmd.op inside {OP_LOAD_UPPER, OP_LOAD_BOTTOM})
    |=> {resultUpperReg_ff[31:0], resultBottomReg_ff[31:0]} == $past(a_ff[31:0]) * $past(b_ff[31:0]))
    else $error("word product wrong");

  AST_WIDE_PRODUCT: assert property (
    done && op_ff == OP_WIDE_PRODUCT && !sgn_ff && !(cmdValid && cmd.op inside {OP_LOAD_UPPER, OP_LOAD_BOTTOM})
    |=> {resultUpperReg_ff, resultBottomReg_ff} == 128'($past(a_ff)) * 128'($past(b_ff)))
    else $error("wide product wrong");

  AST_READ_STALLED: assert property (
    rdReq && busy |=> !rdValid)
    else $error("read served while busy");

  AST_STALL_AFTER_START: assert property (
    longStart |=> stall && busy)
    else $error("no stall after start");

  AST_WORD_DIVIDE: assert property (
    done && op_ff == OP_WORD_QUOTIENT && !sgn_ff && b_ff[31:0] != 32'h0
    && !(cmdValid && cmd.op inside {OP_LOAD_UPPER, OP_LOAD_BOTTOM})
    |=> resultBottomReg_ff[31:0] == $past(a_ff[31:0]) / $past(b_ff[31:0])
        && resultUpperReg_ff[31:0] == $past(a_ff[31:0]) % $past(b_ff[31:0]))
    else $error("quotient or remainder wrong");

  AST_LATENCY: assert property (
    done |-> elapsed_ff == latSel_ff)
    else $error("latency mismatch");

  AST_IDLE_AFTER_DONE: assert property (
    done && !longStart |=> !busy ##1 !stall)
    else $error("unit not released at completion");

  AST_READ_DATA: assert property (
    rdReq && !busy |=> rdValid && rdData == ($past(rdUpper) ? $past(resultUpperReg_ff) : $past(resultBottomReg_ff)))
    else $error("read data wrong");

  AST_LOAD_UPPER: assert property (
    cmdValid && cmd.op == OP_LOAD_UPPER |=> resultUpperReg_ff == $past(cmd.a))
    else $error("move-to upper failed");

  AST_MUL3_LATENCY: assert property (
    gprWrValid |-> m3Elapsed_ff == MUL3_LAT + 7'h01)
    else $error("three-operand latency wrong");

  AST_MUL3_KEEPS_PAIR: assert property (
    mul3Start && !busy && !(cmdValid && cmd.op inside {OP_LOAD_UPPER, OP_LOAD_BOTTOM})
    |=> $stable(resultUpperReg_ff) && $stable(resultBottomReg_ff))
    else $error("three-operand multiply touched result pair");

endmodule

// ==== design/imdu_pkg.sv ====
// shared constants and types of the integer multiply/divide unit
package imdu_pkg;

  localparam int DW = 64;

  // latencies in clocks
  localparam logic [6:0] LAT_MUL_W_BASE = 7'h0c;
  localparam logic [6:0] LAT_DIV_W_BASE = 7'h23;
  localparam logic [6:0] LAT_MUL_W_WIDE = 7'h0a;
  localparam logic [6:0] LAT_DIV_W_WIDE = 7'h2a;
  localparam logic [6:0] LAT_MUL_D      = 7'h0c;
  localparam logic [6:0] LAT_DIV_D      = 7'h4a;
  localparam logic [6:0] LAT_ACCUM      = 7'h04;
  localparam logic [6:0] LAT_MUL3       = 7'h04;

  // values after reset
  localparam logic [63:0] RESULT_RST = 64'h0;
  localparam logic [6:0]  CNT_RST    = 7'h00;

  typedef enum logic [3:0] {
    OP_NONE            = 4'h0,
    OP_WORD_PRODUCT    = 4'h1,
    OP_WORD_QUOTIENT   = 4'h2,
    OP_WIDE_PRODUCT    = 4'h3,
    OP_WIDE_QUOTIENT   = 4'h4,
    OP_ACCUM           = 4'h5,
    OP_MUL3            = 4'h6,
    OP_LOAD_UPPER      = 4'h7,
    OP_LOAD_BOTTOM     = 4'h8
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_RUN  = 2'h2
  } state_t;

  typedef struct packed {
    op_t         op;
    logic        isSigned;
    logic [63:0] a;
    logic [63:0] b;
    logic [4:0]  dest;
  } cmd_t;

endpackage

// ==== sim/pipe_model.sv ====
// integer pipeline model: issues commands and reads the result pair
`timescale 1ns/1ps
module pipe_model import imdu_pkg::*; (
  // clock
  input  wire logic        clk_sys,
  // issue
  output logic             cmdValid,
  output cmd_t             cmd,
  // result read
  output logic             rdReq,
  output logic             rdUpper,
  input  wire logic        stall,
  input  wire logic        rdValid,
  input  wire logic [63:0] rdData
);
  initial begin
    cmdValid = 1'b0;
    cmd      = '0;
    rdReq    = 1'b0;
    rdUpper  = 1'b0;
  end

  // caller hands operands already sign-extended
  task automatic issue(input cmd_t c);
    @(posedge clk_sys);
    cmdValid <= 1'b1;
    cmd      <= c;
    @(posedge clk_sys);
    cmdValid <= 1'b0;
    cmd      <= ~c;
  endtask

  // request held through the stall, wait bounded
  task automatic read(input logic up, output logic [63:0] d, output int waits);
    int n;
    n = 0;
    @(posedge clk_sys);
    rdReq   <= 1'b1;
    rdUpper <= up;
    @(posedge clk_sys);
    #1;
    while (!rdValid && n < 200) begin
      n++;
      @(posedge clk_sys);
      #1;
    end
    d = rdData;
    waits = n;
    @(posedge clk_sys);
    rdReq   <= 1'b0;
    rdUpper <= ~up;
    // quiet slots so a restarted read never sees a new product
    repeat (2) @(posedge clk_sys);
  endtask
endmodule

// ==== sim/testbench.sv ====
// self-checking bench of the multiply/divide unit
`timescale 1ns/1ps
module testbench import imdu_pkg::*;;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        cmdValid, rdReq, rdUpper, stall, rdValid, gprWrValid;
  cmd_t        cmd;
  logic [4:0]  gprWrDest;
  logic [63:0] rdData, gprWrData;
  int          n_fail = 0;
  int          total_checks = 0;

  always #50 clk_sys = ~clk_sys;

  int_multiply_divide_unit #(.WIDE_EN(1'b1), .ACC_EN(1'b1)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .cmdValid(cmdValid), .cmd(cmd),
    .rdReq(rdReq), .rdUpper(rdUpper), .stall(stall), .rdValid(rdValid), .rdData(rdData),
    .gprWrValid(gprWrValid), .gprWrDest(gprWrDest), .gprWrData(gprWrData));

  pipe_model u_pipe (
    .clk_sys(clk_sys), .cmdValid(cmdValid), .cmd(cmd), .rdReq(rdReq),
    .rdUpper(rdUpper), .stall(stall), .rdValid(rdValid), .rdData(rdData));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic cmd_t mk(op_t op, logic s, logic [63:0] a, logic [63:0] b);
    mk = '{op: op, isSigned: s, a: a, b: b, dest: 5'h00};
  endfunction

  // start, count stall cycles, read both halves back
  task automatic run(input cmd_t c, input int lat, input logic [63:0] eu, input logic [63:0] eb);
    logic [63:0] d;
    int n, w;
    n = 0;
    u_pipe.issue(c);
    #1;
    while (stall && n < 200) begin
      n++;
      @(posedge clk_sys);
      #1;
    end
    // stall stands from the cycle after the taking edge through the completion cycle
    check(64'(n), 64'(lat));
    u_pipe.read(1'b1, d, w);
    check(d, eu);
    u_pipe.read(1'b0, d, w);
    check(d, eb);
  endtask

  task automatic t_reset;
    logic [63:0] d;
    int w;
    u_pipe.read(1'b1, d, w);
    check(d, 64'h0);
  endtask

  task automatic t_word;
    run(mk(OP_WORD_PRODUCT, 1'b1, 64'hfffffffffffffffd, 64'h7), 12, '1, 64'hffffffffffffffeb);
    run(mk(OP_WORD_PRODUCT, 1'b0, '1, 64'h2), 12, 64'h1, 64'hfffffffffffffffe);
    run(mk(OP_WORD_QUOTIENT, 1'b1, 64'h64, 64'h7), 35, 64'h2, 64'he);
    run(mk(OP_WORD_QUOTIENT, 1'b1, 64'hffffffffffffff9c, 64'h7), 35, 64'hfffffffffffffffe,
        64'hfffffffffffffff2);
    run(mk(OP_WORD_QUOTIENT, 1'b0, 64'hfffffffffffffff0, 64'h10), 35, 64'h0, 64'hfffffff);
    run(mk(OP_WORD_QUOTIENT, 1'b0, 64'h5, 64'h0), 35, 64'h5, '1);
  endtask

  task automatic t_wide;
    run(mk(OP_WIDE_PRODUCT, 1'b0, 64'h100000001, 64'h100000001), 12, 64'h1, 64'h200000001);
    run(mk(OP_WIDE_PRODUCT, 1'b1, '1, 64'h2), 12, '1, 64'hfffffffffffffffe);
    run(mk(OP_WIDE_PRODUCT, 1'b0, '1, 64'h2), 12, 64'h1, 64'hfffffffffffffffe);
    run(mk(OP_WIDE_QUOTIENT, 1'b0, 64'h100000000, 64'h3), 74, 64'h1, 64'h55555555);
    run(mk(OP_WIDE_QUOTIENT, 1'b1, 64'hfffffffffffffff9, 64'h2), 74, '1, 64'hfffffffffffffffd);
  endtask

  task automatic t_accum;
    u_pipe.issue(mk(OP_LOAD_UPPER, 1'b0, 64'h0, 64'h0));
    run(mk(OP_LOAD_BOTTOM, 1'b0, 64'h5, 64'h0), 0, 64'h0, 64'h5);
    run(mk(OP_ACCUM, 1'b1, 64'h3, 64'h4), 4, 64'h0, 64'h11);
    run(mk(OP_ACCUM, 1'b1, 64'hfffffffffffffffe, 64'h3), 4, 64'h0, 64'hb);
    u_pipe.issue(mk(OP_LOAD_UPPER, 1'b0, 64'h0, 64'h0));
    run(mk(OP_LOAD_BOTTOM, 1'b0, '1, 64'h0), 0, 64'h0, '1);
    run(mk(OP_ACCUM, 1'b0, 64'h1, 64'h1), 4, 64'h1, 64'h0);
  endtask

  task automatic t_mul3;
    logic [63:0] d;
    cmd_t c;
    int n, w;
    u_pipe.issue(mk(OP_LOAD_UPPER, 1'b0, 64'h1234, 64'h0));
    run(mk(OP_LOAD_BOTTOM, 1'b0, 64'h5678, 64'h0), 0, 64'h1234, 64'h5678);
    c = mk(OP_MUL3, 1'b1, 64'hfffffffffffffffe, 64'h3);
    c.dest = 5'h09;
    n = 1;
    u_pipe.issue(c);
    #1;
    while (!gprWrValid && n < 50) begin
      n++;
      @(posedge clk_sys);
      #1;
    end
    check(64'(n), 64'h5);
    check(64'(gprWrDest), 64'h9);
    check(gprWrData, 64'hfffffffffffffffa);
    u_pipe.read(1'b1, d, w);
    check(d, 64'h1234);
    u_pipe.read(1'b0, d, w);
    check(d, 64'h5678);
  endtask

  // read issued mid-divide, with independent work in between
  task automatic t_interlock;
    logic [63:0] d;
    int w;
    u_pipe.issue(mk(OP_WORD_QUOTIENT, 1'b0, 64'h64, 64'h7));
    u_pipe.issue(mk(OP_MUL3, 1'b0, 64'h6, 64'h7));
    u_pipe.read(1'b0, d, w);
    check(d, 64'he);
    check(64'(w > 0), 64'h1);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_word;
    t_wide;
    t_accum;
    t_mul3;
    t_interlock;
    results;
  end

  // whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    results;
  end
endmodule
